// ==== mult_core.sv ====
// combinational 16x16 multiplier with rounding and format adjust
// assumes operands and flags come from registers in the caller
`timescale 1ns/100ps
module mult_core
	import mult_pkg::*;
(
	// operands and latched flags
	input wire operand_s opnd_i,
	input wire logic format_adjust_i,
	// product halves
	output logic [15:0] upper_o,
	output logic [15:0] lower_o
);

	logic signed [16:0] x_ext;
	logic signed [16:0] y_ext;
	logic signed [33:0] full;
	logic [31:0] rounded;

	always_comb begin
		// an extra sign bit lets unsigned and signed share one multiplier
		x_ext = $signed({opnd_i.x_signed & opnd_i.x[15], opnd_i.x});
		y_ext = $signed({opnd_i.y_signed & opnd_i.y[15], opnd_i.y});
		full = x_ext * y_ext;
		rounded = full[31:0];
		if (opnd_i.round) begin
			rounded = full[31:0] + (format_adjust_i ? ROUND_INC_FULL
				: ROUND_INC_SHIFT);
		end
		if (format_adjust_i) begin
			upper_o = rounded[31:16];
			lower_o = rounded[15:0];
		end else begin
			// most negative squared wraps silently, no overflow flag
			upper_o = rounded[30:15];
			lower_o = {rounded[31], rounded[14:0]};
		end
	end

endmodule

// ==== mult_pkg.sv ====
// constants and carriers shared by the multiplier core and its top level
// assumes a single 100 MHz clock and a 32-bit classic wishbone slave port
package mult_pkg;

	// wishbone byte offsets, one aligned word each
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] OPND_OFS = 4'h4;
	localparam logic [3:0] PROD_OFS = 4'h8;
	localparam logic [3:0] FLAG_OFS = 4'hC;

	// control word layout, low bits of CTRL
	typedef struct packed {
		logic dedicated_port_drive_n;
		logic lower_port_drive_n;
		logic output_half_select;
		logic feedthrough_sel;
		logic format_adjust;
		logic single_clock_mode;
	} ctrl_s;

	localparam int CTRL_W = 6;
	// both ports released, full product format, separate-clock variant
	localparam logic [5:0] CTRL_RESET = 6'h32;

	// round increments: full format adds at bit 15, shifted at bit 14
	localparam logic [31:0] ROUND_INC_FULL = 32'h0000_8000;
	localparam logic [31:0] ROUND_INC_SHIFT = 32'h0000_4000;

	// positions in the sampled dedicated clock vector
	localparam int XCLK_BIT = 0;
	localparam int YCLK_BIT = 1;
	localparam int UCLK_BIT = 2;
	localparam int LCLK_BIT = 3;

	// operand side of the datapath
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic x_signed;
		logic y_signed;
		logic round;
	} operand_s;

	// whole state of the top level
	typedef struct packed {
		ctrl_s ctrl;
		operand_s opnd;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [3:0] clk_prev;
		logic ack;
		logic [31:0] rdata;
	} state_s;

endpackage

// ==== mult_top.sv ====
// registered 16x16 multiplier top: operand and product registers,
// output steering and a wishbone slave for control and readback
// assumes all pins synchronous to clk_i; dedicated clocks are sampled
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module mult_top
	import mult_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// operand inputs and flags
	input wire logic [15:0] x_data_i,
	input wire logic x_signed_sel_i,
	input wire logic y_signed_sel_i,
	input wire logic round_request_i,
	// separate-clock variant load clocks, sampled for rising edges
	input wire logic x_operand_clock_i,
	input wire logic y_operand_clock_i,
	input wire logic upper_product_clock_i,
	input wire logic lower_product_clock_i,
	// single-clock variant enables
	input wire logic x_load_enable_n_i,
	input wire logic y_load_enable_n_i,
	input wire logic product_load_enable_n_i,
	// shared y operand / lower product port
	input wire logic [15:0] y_port_i,
	output logic [15:0] y_port_o,
	output logic y_port_oe_o,
	// dedicated product port
	output logic [15:0] dedicated_port_o,
	output logic dedicated_port_oe_o
);

	state_s s_reg;
	state_s s_next;
	logic [15:0] upper_comb;
	logic [15:0] lower_comb;
	logic [3:0] clk_now;
	logic [3:0] clk_rise;
	logic x_load;
	logic y_load;
	logic upper_load;
	logic lower_load;
	logic bus_req;
	logic [15:0] upper_out;
	logic [15:0] lower_out;

	mult_core u_core (
		.opnd_i(s_reg.opnd),
		.format_adjust_i(s_reg.ctrl.format_adjust),
		.upper_o(upper_comb),
		.lower_o(lower_comb)
	);

	assign clk_now = {lower_product_clock_i, upper_product_clock_i,
		y_operand_clock_i, x_operand_clock_i};
	assign clk_rise = clk_now & ~s_reg.clk_prev;
	assign bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;

	always_comb begin
		if (s_reg.ctrl.single_clock_mode) begin
			x_load = ~x_load_enable_n_i;
			y_load = ~y_load_enable_n_i;
			upper_load = ~product_load_enable_n_i;
			lower_load = ~product_load_enable_n_i;
		end else begin
			x_load = clk_rise[XCLK_BIT];
			y_load = clk_rise[YCLK_BIT];
			upper_load = clk_rise[UCLK_BIT];
			lower_load = clk_rise[LCLK_BIT];
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.clk_prev = clk_now;
		if (x_load) begin
			s_next.opnd.x = x_data_i;
			s_next.opnd.x_signed = x_signed_sel_i;
		end
		if (y_load) begin
			// y arrives on the shared port; drive must be released then
			s_next.opnd.y = y_port_i;
			s_next.opnd.y_signed = y_signed_sel_i;
		end
		if (x_load | y_load) begin
			s_next.opnd.round = round_request_i;
		end
		if (upper_load) begin
			s_next.upper = upper_comb;
		end
		if (lower_load) begin
			s_next.lower = lower_comb;
		end
		// one registered ack per request, raised a cycle later and dropped the cycle after
		s_next.ack = bus_req;
		s_next.rdata = 32'h0000_0000;
		if (bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == CTRL_OFS)) begin
			s_next.ctrl = ctrl_s'(wb_dat_i[CTRL_W-1:0]);
		end
		if (bus_req & ~wb_we_i) begin
			unique case (wb_adr_i)
				CTRL_OFS: begin
					s_next.rdata = {26'h0, s_reg.ctrl};
				end
				OPND_OFS: begin
					s_next.rdata = {s_reg.opnd.y, s_reg.opnd.x};
				end
				PROD_OFS: begin
					s_next.rdata = {upper_out, lower_out};
				end
				FLAG_OFS: begin
					s_next.rdata = {29'h0, s_reg.opnd.round,
						s_reg.opnd.y_signed, s_reg.opnd.x_signed};
				end
				default: begin
					s_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.ctrl <= ctrl_s'(CTRL_RESET);
		end else begin
			s_reg <= s_next;
		end
	end

	// feedthrough bypasses the product registers, trading a registered
	// output for zero latency
	assign upper_out = s_reg.ctrl.feedthrough_sel ? upper_comb
		: s_reg.upper;
	assign lower_out = s_reg.ctrl.feedthrough_sel ? lower_comb
		: s_reg.lower;
	assign dedicated_port_o = s_reg.ctrl.output_half_select ? lower_out
		: upper_out;
	assign dedicated_port_oe_o = ~s_reg.ctrl.dedicated_port_drive_n;
	assign y_port_o = lower_out;
	assign y_port_oe_o = ~s_reg.ctrl.lower_port_drive_n;
	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdata;

	// checks
	// reference products built independently of the core's extension trick
	logic signed [31:0] mixed_ref;
	logic signed [31:0] signed_ref;
	logic [31:0] shift_ref;

	assign mixed_ref = $signed(s_reg.opnd.x) * $signed({1'b0, s_reg.opnd.y});
	assign signed_ref = $signed(s_reg.opnd.x) * $signed(s_reg.opnd.y);
	assign shift_ref = signed_ref + ROUND_INC_SHIFT;

	sequence s_y_rise_sep;
		!s_reg.ctrl.single_clock_mode && y_operand_clock_i
			&& !s_reg.clk_prev[YCLK_BIT];
	endsequence

	sequence s_x_rise_sep;
		!s_reg.ctrl.single_clock_mode && x_operand_clock_i
			&& !s_reg.clk_prev[XCLK_BIT];
	endsequence

	sequence s_y_load_single;
		s_reg.ctrl.single_clock_mode && !y_load_enable_n_i;
	endsequence

	property p_x_capture;
		@(posedge clk_i) disable iff (rst_i)
		s_x_rise_sep |=>
			s_reg.opnd.x == $past(x_data_i)
			&& s_reg.opnd.x_signed == $past(x_signed_sel_i);
	endproperty
	a_x_capture: assert property (p_x_capture)
		else $error("x register did not capture on its clock");

	property p_x_hold;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.single_clock_mode && x_load_enable_n_i |=>
			$stable(s_reg.opnd.x) && $stable(s_reg.opnd.x_signed);
	endproperty
	a_x_hold: assert property (p_x_hold)
		else $error("x register changed while its enable was high");

	property p_round_latch;
		@(posedge clk_i) disable iff (rst_i)
		s_y_load_single |=> s_reg.opnd.round == $past(round_request_i)
			&& s_reg.opnd.y == $past(y_port_i);
	endproperty
	a_round_latch: assert property (p_round_latch)
		else $error("round flag not latched with y load");

	property p_upper_capture;
		@(posedge clk_i) disable iff (rst_i)
		!s_reg.ctrl.single_clock_mode && upper_product_clock_i
			&& !s_reg.clk_prev[UCLK_BIT]
			|=> s_reg.upper == $past(upper_comb);
	endproperty
	a_upper_capture: assert property (p_upper_capture)
		else $error("upper product register missed its clock");

	property p_product_hold;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.single_clock_mode && product_load_enable_n_i |=>
			$stable(s_reg.upper) && $stable(s_reg.lower);
	endproperty
	a_product_hold: assert property (p_product_hold)
		else $error("product registers changed while disabled");

	property p_feedthrough;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.feedthrough_sel && !s_reg.ctrl.output_half_select
			|-> dedicated_port_o == upper_comb;
	endproperty
	a_feedthrough: assert property (p_feedthrough)
		else $error("feedthrough did not bypass the upper register");

	property p_half_select;
		@(posedge clk_i) disable iff (rst_i)
		!s_reg.ctrl.feedthrough_sel |->
			dedicated_port_o == (s_reg.ctrl.output_half_select
			? s_reg.lower : s_reg.upper);
	endproperty
	a_half_select: assert property (p_half_select)
		else $error("dedicated port shows the wrong half");

	property p_lower_drive;
		@(posedge clk_i) disable iff (rst_i)
		y_port_oe_o == !s_reg.ctrl.lower_port_drive_n
			&& y_port_o == (s_reg.ctrl.feedthrough_sel ? lower_comb
			: s_reg.lower);
	endproperty
	a_lower_drive: assert property (p_lower_drive)
		else $error("shared port not driven with lower half");

	property p_full_format;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.format_adjust && !s_reg.opnd.round
			&& !s_reg.opnd.x_signed && !s_reg.opnd.y_signed
			|-> {upper_comb, lower_comb}
			== {16'h0000, s_reg.opnd.x} * {16'h0000, s_reg.opnd.y};
	endproperty
	a_full_format: assert property (p_full_format)
		else $error("unsigned full product mismatch");

	property p_round_full;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.format_adjust && s_reg.opnd.round
			&& !s_reg.opnd.x_signed && !s_reg.opnd.y_signed
			|-> {upper_comb, lower_comb}
			== {16'h0000, s_reg.opnd.x} * {16'h0000, s_reg.opnd.y}
			+ ROUND_INC_FULL;
	endproperty
	a_round_full: assert property (p_round_full)
		else $error("round not added at bit 15");

	property p_shift_overflow;
		@(posedge clk_i) disable iff (rst_i)
		!s_reg.ctrl.format_adjust && !s_reg.opnd.round
			&& s_reg.opnd.x_signed && s_reg.opnd.y_signed
			&& s_reg.opnd.x == 16'h8000 && s_reg.opnd.y == 16'h8000
			|-> upper_comb == 16'h8000 && lower_comb == 16'h0000;
	endproperty
	a_shift_overflow: assert property (p_shift_overflow)
		else $error("shifted most negative square not wrapped");

	property p_bus_ack;
		@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack)
		else $error("wishbone ack not a single cycle after request");

	property p_y_capture;
		@(posedge clk_i) disable iff (rst_i)
		s_y_rise_sep |=> s_reg.opnd.y == $past(y_port_i)
			&& s_reg.opnd.y_signed == $past(y_signed_sel_i)
			&& s_reg.opnd.round == $past(round_request_i);
	endproperty
	a_y_capture: assert property (p_y_capture)
		else $error("y register did not capture on its clock");

	property p_lower_capture;
		@(posedge clk_i) disable iff (rst_i)
		!s_reg.ctrl.single_clock_mode && lower_product_clock_i
			&& !s_reg.clk_prev[LCLK_BIT]
			|=> s_reg.lower == $past(lower_comb);
	endproperty
	a_lower_capture: assert property (p_lower_capture)
		else $error("lower product register missed its clock");

	property p_x_load_single;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.single_clock_mode && !x_load_enable_n_i |=>
			s_reg.opnd.x == $past(x_data_i)
			&& s_reg.opnd.x_signed == $past(x_signed_sel_i);
	endproperty
	a_x_load_single: assert property (p_x_load_single)
		else $error("x register did not load with its enable low");

	property p_product_load;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.single_clock_mode && !product_load_enable_n_i |=>
			s_reg.upper == $past(upper_comb)
			&& s_reg.lower == $past(lower_comb);
	endproperty
	a_product_load: assert property (p_product_load)
		else $error("product registers did not load with enable low");

	property p_mixed_mode;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.ctrl.format_adjust && !s_reg.opnd.round
			&& s_reg.opnd.x_signed && !s_reg.opnd.y_signed
			|-> {upper_comb, lower_comb} == mixed_ref;
	endproperty
	a_mixed_mode: assert property (p_mixed_mode)
		else $error("signed by unsigned product mismatch");

	property p_round_shift;
		@(posedge clk_i) disable iff (rst_i)
		!s_reg.ctrl.format_adjust && s_reg.opnd.round
			&& s_reg.opnd.x_signed && s_reg.opnd.y_signed
			|-> upper_comb == shift_ref[30:15]
			&& lower_comb == {shift_ref[31], shift_ref[14:0]};
	endproperty
	a_round_shift: assert property (p_round_shift)
		else $error("shifted format or bit 14 round wrong");

endmodule

// ==== registered_16x16_multiplier_bench.sv ====
// self-checking bench for mult_top: wishbone tasks plus operand strobes
// assumes the designer's one-cycle ack and edge-sampled load inputs
`timescale 1ns/100ps
`define CHK(a, b) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		err_total++; \
		$display("ERROR %0t got %h exp %h", $time, (a), (b)); \
	end \
end
module registered_16x16_multiplier_bench import mult_pkg::*;;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, host_en;
	logic [3:0] wb_adr_i, wb_sel_i, dclk;
	logic [31:0] wb_dat_i, wb_dat_o, d, e, e_old;
	logic [15:0] x_data_i, host_y, y_port_i, y_port_o, dedicated_port_o;
	logic [2:0] en_n, fl;
	logic y_port_oe_o, dedicated_port_oe_o;
	logic [35:0] t;
	int err_total, total_checks;
	// {x, y, x_signed, y_signed, round, format_adjust}
	logic [35:0] tc [7] = '{{32'hFFFF_FFFF, 4'b0001}, {32'h8000_8000, 4'b1100},
		{32'h8000_8000, 4'b1101}, {32'hFFFF_0003, 4'b1001},
		{32'h1234_5678, 4'b1111}, {32'h7FFF_C001, 4'b1110},
		{32'h0003_8000, 4'b0101}};
	mult_top u_mult_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .x_data_i(x_data_i), .x_signed_sel_i(fl[2]),
		.y_signed_sel_i(fl[1]), .round_request_i(fl[0]),
		.x_operand_clock_i(dclk[3]), .y_operand_clock_i(dclk[2]),
		.upper_product_clock_i(dclk[1]), .lower_product_clock_i(dclk[0]),
		.x_load_enable_n_i(en_n[2]), .y_load_enable_n_i(en_n[1]),
		.product_load_enable_n_i(en_n[0]), .y_port_i(y_port_i),
		.y_port_o(y_port_o), .y_port_oe_o(y_port_oe_o),
		.dedicated_port_o(dedicated_port_o),
		.dedicated_port_oe_o(dedicated_port_oe_o));
	ypin_model u_ypin_model (.clk_i(clk_i), .host_en_i(host_en),
		.host_val_i(host_y), .dev_oe_i(y_port_oe_o), .dev_val_i(y_port_o),
		.pin_o(y_port_i));
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] exp_p(logic [15:0] x, y,
		logic xs, ys, rn, fa);
		logic signed [33:0] p;
		logic [31:0] r;
		p = $signed({xs & x[15], x}) * $signed({ys & y[15], y});
		r = p[31:0] + (rn ? (fa ? ROUND_INC_FULL : ROUND_INC_SHIFT) : 32'h0);
		return fa ? r : {r[30:15], r[31], r[14:0]};
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		n = 0;
		// ack and read data are taken at the rising edge that samples ack
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			finish_test();
		end else begin
			d = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask
	// s = {x en, y en, product en, x clk, y clk, upper clk, lower clk}
	task automatic ld(input logic [15:0] x, y, input logic [2:0] f,
		input logic [6:0] s);
		@(posedge clk_i);
		x_data_i <= x;
		host_y <= y;
		fl <= f;
		en_n <= ~s[6:4];
		dclk <= s[3:0];
		@(posedge clk_i);
		en_n <= 3'b111;
		dclk <= 4'h0;
		@(posedge clk_i);
	endtask
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, x_data_i} = '0;
		{host_y, fl, dclk} = '0;
		wb_sel_i = 4'hF;
		en_n = 3'b111;
		host_en = 1'b1;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, CTRL_OFS, 0);
		`CHK(d, 32'h32)
		`CHK(y_port_oe_o, 1'b0)
		`CHK(dedicated_port_oe_o, 1'b0)
		wb(0, PROD_OFS, 0);
		`CHK(d, 32'h0)
		wb(0, 4'h2, 0);
		`CHK(d, 32'h0)
		wb(1, OPND_OFS, 32'hFFFF_FFFF);
		wb(0, OPND_OFS, 0);
		`CHK(d, 32'h0)
		for (int i = 0; i < 7; i++) begin
			t = tc[i];
			e = exp_p(t[35:20], t[19:4], t[3], t[2], t[1], t[0]);
			wb(1, CTRL_OFS, {26'h0, 4'b0100, t[0], 1'b1});
			ld(t[35:20], t[19:4], t[3:1], 7'b110_0000);
			ld(t[35:20], t[19:4], t[3:1], 7'b001_0000);
			wb(0, PROD_OFS, 0);
			`CHK(d, e)
			`CHK(dedicated_port_o, e[31:16])
			`CHK(dedicated_port_oe_o, 1'b1)
			wb(1, CTRL_OFS, {26'h0, 4'b0110, t[0], 1'b1});
			`CHK(dedicated_port_o, e[15:0])
		end
		ld(16'h1234, 16'h5678, 3'b111, 7'b001_0000);
		wb(0, PROD_OFS, 0);
		`CHK(d, e)
		ld(16'h1234, 16'h0100, 3'b001, 7'b010_0000);
		ld(16'h1234, 16'h0100, 3'b001, 7'b001_0000);
		e = exp_p(16'h0003, 16'h0100, 0, 0, 1, 1);
		wb(0, PROD_OFS, 0);
		`CHK(d, e)
		e_old = e;
		wb(1, CTRL_OFS, 32'h12);
		ld(16'h0201, 16'h0301, 3'b000, 7'b000_1100);
		ld(16'h0201, 16'h0301, 3'b000, 7'b000_0010);
		e = exp_p(16'h0201, 16'h0301, 0, 0, 0, 1);
		wb(0, PROD_OFS, 0);
		`CHK(d, {e[31:16], e_old[15:0]})
		ld(16'h0201, 16'h0301, 3'b000, 7'b000_0001);
		wb(0, PROD_OFS, 0);
		`CHK(d, e)
		host_en <= 1'b0;
		// feedthrough on, upper half on the dedicated port, lower port driven
		wb(1, CTRL_OFS, 32'h06);
		ld(16'h0005, 16'h0000, 3'b000, 7'b000_1000);
		e = exp_p(16'h0005, 16'h0301, 0, 0, 0, 1);
		`CHK(y_port_oe_o, 1'b1)
		`CHK(y_port_o, e[15:0])
		`CHK(y_port_i, e[15:0])
		`CHK(dedicated_port_o, e[31:16])
		wb(0, PROD_OFS, 0);
		`CHK(d, e)
		finish_test();
	end
endmodule

// ==== ypin_model.sv ====
// model of the host side of the shared y operand / lower product pin
// assumes the host drives only while the device output is released
`timescale 1ns/100ps
module ypin_model (
	// clock
	input wire logic clk_i,
	// drivers
	input wire logic host_en_i,
	input wire logic [15:0] host_val_i,
	input wire logic dev_oe_i,
	input wire logic [15:0] dev_val_i,
	// resolved pin
	output logic [15:0] pin_o
);
	logic [15:0] last_reg;
	always_ff @(posedge clk_i) begin
		last_reg <= pin_o;
	end
	// a floating pin toggles so a stale value can never look valid
	assign pin_o = dev_oe_i ? dev_val_i
		: host_en_i ? host_val_i : ~last_reg;
endmodule
